/* rtl/fsc_pkg.sv */
// Constants and carrier types for the flash supervisory call unit
`default_nettype none
package fsc_pkg;
    // Trap opcode and guard key value
    localparam logic [7:0] CALL_OPCODE = 8'h00;
    localparam logic [7:0] GUARD1_VALUE = 8'h3A;
    localparam logic [7:0] GUARD2_SP_OFFSET = 8'h03;
    // Function codes held in the accumulator
    localparam logic [7:0] FN_BOOT = 8'h00;
    localparam logic [7:0] FN_READ = 8'h01;
    localparam logic [7:0] FN_WRITE = 8'h02;
    localparam logic [7:0] FN_ERASE = 8'h03;
    localparam logic [7:0] FN_ERASE_ALL = 8'h05;
    localparam logic [7:0] FN_TABLE = 8'h06;
    localparam logic [7:0] FN_CSUM = 8'h07;
    // Parameter block, page 0, first byte and slot indices
    localparam logic [7:0] PRM_BASE = 8'hF8;
    localparam logic [2:0] PRM_GUARD1 = 3'h0;
    localparam logic [2:0] PRM_GUARD2 = 3'h1;
    localparam logic [2:0] PRM_BLOCK = 3'h2;
    localparam logic [2:0] PRM_PTR = 3'h3;
    localparam logic [2:0] PRM_CLK = 3'h4;
    localparam logic [2:0] PRM_DELAY = 3'h6;
    localparam logic [2:0] PRM_LAST = 3'h7;
    // Return codes
    localparam logic [7:0] RC_OK = 8'h00;
    localparam logic [7:0] RC_PROT = 8'h01;
    localparam logic [7:0] RC_SWRST = 8'h02;
    localparam logic [7:0] RC_FATAL = 8'h03;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Protection level bits: bit 0 blocks reads, bit 1 external writes
    localparam logic [1:0] PROT_FULL = 2'h3;
    localparam int PROT_RD_BIT = 0;
    localparam int PROT_EXTWR_BIT = 1;
    // Programming-pin entry: least hold time and clock rate
    localparam int ISP_HOLD_NS = 1000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int ISP_HOLD_CYC = (ISP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Flash engine operations and targets
    typedef enum logic [2:0] {
        FOP_BOOT = 3'h0, FOP_READ = 3'h1, FOP_WRITE = 3'h2, FOP_ERASE = 3'h3,
        FOP_PROG0 = 3'h4, FOP_TABLE = 3'h5, FOP_CSUM = 3'h6
    } fsc_fop_e;
    typedef enum logic [1:0] {
        TGT_USER = 2'h0, TGT_MACRO = 2'h1, TGT_PROT = 2'h2
    } fsc_tgt_e;
    // Request to the parameter SRAM
    typedef struct packed {
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fsc_sram_s;
    // Request to the flash programming engine
    typedef struct packed {
        logic start;
        fsc_fop_e op;
        fsc_tgt_e tgt;
        logic [7:0] blk;
        logic [7:0] ptr;
        logic [7:0] clkdiv;
        logic [7:0] delay;
    } fsc_flash_s;
endpackage : fsc_pkg
`default_nettype wire

/* rtl/fsc_unit.sv */
// Supervisory call unit: key check, dispatch and flash sequencing
//
// What this block does
// - Opcode 00h traps into supervisory ROM by accumulator
// - Decode function codes 00,01,02,03,05,06,07
// - Undefined function from user code halts core
// - Bad key halts, except boot reset function
// - Parameter block lives at page 0 F8h-FFh
// - Return code lands in first key slot
// - Codes: 00 ok, 01 protect, 02 reset, 03 fatal
// - Refuse read/write/erase that protection level forbids
// - Flash control visible only inside supervisory ROM
// - Full erase never touches the auxiliary rows
// - Full erase: macro erase/zero/erase, then protection blocks
// - Pin pattern enters serial programming via test queue
// - Refusal clears accumulator and second key, leaves 01h
`default_nettype none
module fsc_unit #(
    parameter int N_MACRO = 2,   // Flash macros in the part
    parameter int N_PROT = 2     // Protection blocks to scrub
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Core instruction side
    input wire logic CALL_VALID_I,
    input wire logic [7:0] OPCODE_I,
    input wire logic [7:0] ACC_I,
    input wire logic [7:0] SP_I,
    output logic CALL_READY_O,
    output logic ACC_CLR_O,
    output logic HALT_O,
    output logic ROM_ACTIVE_O,
    // Parameter SRAM port
    output fsc_pkg::fsc_sram_s SRAM_O,
    input wire logic SRAM_ACK_I,
    input wire logic [7:0] SRAM_RDATA_I,
    // Flash engine and protection lookup
    output fsc_pkg::fsc_flash_s FLASH_O,
    input wire logic FLASH_DONE_I,
    input wire logic FLASH_ERR_I,
    input wire logic [7:0] FLASH_DATA_I,
    input wire logic [1:0] PROT_LEVEL_I,
    // Serial programming pins and test queue
    input wire logic USB_DP_I,
    input wire logic USB_DM_I,
    input wire logic TQ_VALID_I,
    input wire logic [7:0] TQ_FUNC_I,
    output logic ISP_MODE_O
);
    // One-hot sequencer states
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001, S_PRM = 7'b0000010, S_CHK = 7'b0000100,
        S_PROT = 7'b0001000, S_FLASH = 7'b0010000, S_WR = 7'b0100000,
        S_HALT = 7'b1000000
    } fsc_st_e;

    // Whole state of the unit
    typedef struct packed {
        fsc_st_e st;
        logic [7:0] func;         // Latched function code
        logic [7:0] sp_key;       // Expected second key
        logic ext;                // Call came from test queue
        logic hw_boot;            // Boot after hardware reset pending
        logic boot_hw;            // Running boot is the reset one
        logic [7:0][7:0] prm;     // Parameter block copy
        logic [2:0] idx;          // Parameter byte index
        logic phase;              // Full erase: 0 macros, 1 protection
        logic [1:0] step;         // Full erase step in a pass
        logic [7:0] unit;         // Macro or protection block number
        logic [7:0] rc;           // Return byte
        logic wr2;                // Second key still to clear
        logic halt_after;         // Halt once code is stored
        logic acc_clr;
        logic halt;
        logic dp1, dp2, dm1, dm2; // Pin synchronisers
        logic [15:0] isp_cnt;
        logic isp;
        logic ready;              // Call will be taken
        logic rom;                // Supervisory rom running
        fsc_pkg::fsc_sram_s sram;
        fsc_pkg::fsc_flash_s flash;
    } fsc_state_s;

    fsc_state_s s_ff;
    fsc_state_s nxt_s;
    logic call_go;
    logic user_go;
    logic [7:0] fn_in;

    // Defined function codes other than boot (00h)
    function automatic logic fn_known(input logic [7:0] f);
        fn_known = (f == fsc_pkg::FN_READ) || (f == fsc_pkg::FN_WRITE) ||
            (f == fsc_pkg::FN_ERASE) || (f == fsc_pkg::FN_ERASE_ALL) ||
            (f == fsc_pkg::FN_TABLE) || (f == fsc_pkg::FN_CSUM);
    endfunction : fn_known

    // Full-erase step to flash operation; auxiliary rows never targeted
    function automatic fsc_pkg::fsc_fop_e ea_op(input logic [1:0] st);
        ea_op = (st == 2'h1) ? fsc_pkg::FOP_PROG0 : fsc_pkg::FOP_ERASE;
    endfunction : ea_op

    // User opcode trap or test-queue call; only while idle
    assign user_go = CALL_VALID_I && (OPCODE_I == fsc_pkg::CALL_OPCODE);
    assign call_go = (s_ff.st == S_IDLE) && !s_ff.hw_boot &&
        (user_go || (s_ff.isp && TQ_VALID_I));
    assign fn_in = user_go ? ACC_I : TQ_FUNC_I;

    // Next-state logic
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.flash.start = 1'b0;
        nxt_s.acc_clr = 1'b0;
        // Programming-pin entry: D+ high, D- low held long enough
        nxt_s.dp1 = USB_DP_I;
        nxt_s.dp2 = s_ff.dp1;
        nxt_s.dm1 = USB_DM_I;
        nxt_s.dm2 = s_ff.dm1;
        if (s_ff.dp2 && !s_ff.dm2)
        begin
            if (s_ff.isp_cnt == 16'(fsc_pkg::ISP_HOLD_CYC - 1))
                nxt_s.isp = 1'b1;
            else
                nxt_s.isp_cnt = s_ff.isp_cnt + 16'h0001;
        end
        else
        begin
            nxt_s.isp_cnt = 16'h0000;
        end
        unique case (s_ff.st)
            S_IDLE:
            begin
                if (s_ff.hw_boot)
                begin
                    // Boot after reset needs no parameters
                    nxt_s.hw_boot = 1'b0;
                    nxt_s.boot_hw = 1'b1;
                    nxt_s.func = fsc_pkg::FN_BOOT;
                    nxt_s.flash.op = fsc_pkg::FOP_BOOT;
                    nxt_s.flash.start = 1'b1;
                    nxt_s.st = S_FLASH;
                end
                else if (call_go)
                begin
                    nxt_s.func = fn_in;
                    nxt_s.ext = !user_go;
                    nxt_s.boot_hw = 1'b0;
                    nxt_s.sp_key = SP_I + fsc_pkg::GUARD2_SP_OFFSET;
                    if (fn_in == fsc_pkg::FN_BOOT)
                    begin
                        // Boot skips the keys entirely
                        nxt_s.flash.op = fsc_pkg::FOP_BOOT;
                        nxt_s.flash.start = 1'b1;
                        nxt_s.st = S_FLASH;
                    end
                    else if (!fn_known(fn_in))
                    begin
                        // Unknown code: halt for user, ignore for queue
                        nxt_s.st = user_go ? S_HALT : S_IDLE;
                        nxt_s.halt = user_go;
                    end
                    else
                    begin
                        // Fetch the whole parameter block
                        nxt_s.idx = 3'h0;
                        nxt_s.sram = '{req: 1'b1, we: 1'b0,
                            addr: fsc_pkg::PRM_BASE, wdata: fsc_pkg::ZERO_BYTE};
                        nxt_s.st = S_PRM;
                    end
                end
            end
            S_PRM:
            begin
                if (SRAM_ACK_I)
                begin
                    nxt_s.prm[s_ff.idx] = SRAM_RDATA_I;
                    if (s_ff.idx == fsc_pkg::PRM_LAST)
                    begin
                        nxt_s.sram.req = 1'b0;
                        nxt_s.st = S_CHK;
                    end
                    else
                    begin
                        nxt_s.idx = s_ff.idx + 3'h1;
                        nxt_s.sram.addr = s_ff.sram.addr + 8'h01;
                    end
                end
            end
            S_CHK:
            begin
                nxt_s.flash.blk = s_ff.prm[fsc_pkg::PRM_BLOCK];
                nxt_s.flash.ptr = s_ff.prm[fsc_pkg::PRM_PTR];
                nxt_s.flash.clkdiv = s_ff.prm[fsc_pkg::PRM_CLK];
                nxt_s.flash.delay = s_ff.prm[fsc_pkg::PRM_DELAY];
                nxt_s.flash.tgt = fsc_pkg::TGT_USER;
                if ((s_ff.prm[fsc_pkg::PRM_GUARD1] != fsc_pkg::GUARD1_VALUE) ||
                    (s_ff.prm[fsc_pkg::PRM_GUARD2] != s_ff.sp_key))
                begin
                    nxt_s.halt = 1'b1;
                    nxt_s.st = S_HALT;
                end
                else if (s_ff.func == fsc_pkg::FN_ERASE_ALL)
                begin
                    nxt_s.phase = 1'b0;
                    nxt_s.step = 2'h0;
                    nxt_s.unit = 8'h00;
                    nxt_s.flash.tgt = fsc_pkg::TGT_MACRO;
                    nxt_s.flash.blk = 8'h00;
                    nxt_s.flash.op = ea_op(2'h0);
                    nxt_s.flash.start = 1'b1;
                    nxt_s.st = S_FLASH;
                end
                else if ((s_ff.func == fsc_pkg::FN_TABLE) ||
                    (s_ff.func == fsc_pkg::FN_CSUM))
                begin
                    nxt_s.flash.op = (s_ff.func == fsc_pkg::FN_TABLE) ?
                        fsc_pkg::FOP_TABLE : fsc_pkg::FOP_CSUM;
                    nxt_s.flash.start = 1'b1;
                    nxt_s.st = S_FLASH;
                end
                else
                begin
                    // Block lookup settles while in the protection state
                    nxt_s.st = S_PROT;
                end
            end
            S_PROT:
            begin
                // Reads: bit 0; queue writes: bit 1; full blocks all writes
                if (((s_ff.func == fsc_pkg::FN_READ) && PROT_LEVEL_I[fsc_pkg::PROT_RD_BIT]) ||
                    ((s_ff.func != fsc_pkg::FN_READ) &&
                    ((PROT_LEVEL_I == fsc_pkg::PROT_FULL) ||
                    (s_ff.ext && PROT_LEVEL_I[fsc_pkg::PROT_EXTWR_BIT]))))
                begin
                    nxt_s.rc = fsc_pkg::RC_PROT;
                    nxt_s.acc_clr = 1'b1;
                    nxt_s.wr2 = 1'b1;
                    nxt_s.sram = '{req: 1'b1, we: 1'b1,
                        addr: fsc_pkg::PRM_BASE, wdata: fsc_pkg::RC_PROT};
                    nxt_s.st = S_WR;
                end
                else
                begin
                    nxt_s.flash.op = (s_ff.func == fsc_pkg::FN_READ) ? fsc_pkg::FOP_READ :
                        (s_ff.func == fsc_pkg::FN_WRITE) ? fsc_pkg::FOP_WRITE :
                        fsc_pkg::FOP_ERASE;
                    nxt_s.flash.start = 1'b1;
                    nxt_s.st = S_FLASH;
                end
            end
            S_FLASH:
            begin
                if (FLASH_DONE_I)
                begin
                    if (FLASH_ERR_I)
                    begin
                        nxt_s.rc = fsc_pkg::RC_FATAL;
                        nxt_s.halt_after = 1'b1;
                    end
                    else if ((s_ff.func == fsc_pkg::FN_ERASE_ALL) &&
                        !(s_ff.phase && (s_ff.step == 2'h1) &&
                        (s_ff.unit == 8'(N_PROT - 1))))
                    begin
                        // Advance the erase/zero/erase walk
                        nxt_s.flash.start = 1'b1;
                        if ((!s_ff.phase && (s_ff.step == 2'h2)) ||
                            (s_ff.phase && (s_ff.step == 2'h1)))
                        begin
                            nxt_s.step = 2'h0;
                            if (!s_ff.phase && (s_ff.unit == 8'(N_MACRO - 1)))
                            begin
                                nxt_s.phase = 1'b1;
                                nxt_s.unit = 8'h00;
                                nxt_s.flash.tgt = fsc_pkg::TGT_PROT;
                            end
                            else
                            begin
                                nxt_s.unit = s_ff.unit + 8'h01;
                            end
                        end
                        else
                        begin
                            nxt_s.step = s_ff.step + 2'h1;
                        end
                        nxt_s.flash.blk = nxt_s.unit;
                        nxt_s.flash.op = ea_op(nxt_s.step);
                    end
                    else if ((s_ff.func == fsc_pkg::FN_TABLE) ||
                        (s_ff.func == fsc_pkg::FN_CSUM))
                    begin
                        nxt_s.rc = FLASH_DATA_I;
                    end
                    else
                    begin
                        nxt_s.rc = (s_ff.func == fsc_pkg::FN_BOOT) ?
                            fsc_pkg::RC_SWRST : fsc_pkg::RC_OK;
                    end
                    // Reset boot leaves the parameter block alone
                    if (!nxt_s.flash.start)
                    begin
                        nxt_s.st = s_ff.boot_hw ? S_IDLE : S_WR;
                        nxt_s.sram = '{req: !s_ff.boot_hw, we: 1'b1,
                            addr: fsc_pkg::PRM_BASE, wdata: nxt_s.rc};
                    end
                end
            end
            S_WR:
            begin
                if (SRAM_ACK_I)
                begin
                    if (s_ff.wr2)
                    begin
                        // Refusal also zeroes the second key
                        nxt_s.wr2 = 1'b0;
                        nxt_s.sram.addr = fsc_pkg::PRM_BASE + 8'(fsc_pkg::PRM_GUARD2);
                        nxt_s.sram.wdata = fsc_pkg::ZERO_BYTE;
                    end
                    else
                    begin
                        nxt_s.sram.req = 1'b0;
                        nxt_s.halt = s_ff.halt_after;
                        nxt_s.st = s_ff.halt_after ? S_HALT : S_IDLE;
                    end
                end
            end
            S_HALT:
            begin
                // Only reset leaves a halt
                nxt_s.halt = 1'b1;
            end
        endcase
        // Status outputs decoded ahead so they leave straight from flops
        nxt_s.ready = (nxt_s.st == S_IDLE) && !nxt_s.hw_boot;
        nxt_s.rom = (nxt_s.st != S_IDLE) && (nxt_s.st != S_HALT);
    end

    // State register
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            s_ff <= '0;
            s_ff.st <= S_IDLE;
            s_ff.hw_boot <= 1'b1;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register
    assign CALL_READY_O = s_ff.ready;
    assign ROM_ACTIVE_O = s_ff.rom;
    assign ACC_CLR_O = s_ff.acc_clr;
    assign HALT_O = s_ff.halt;
    assign SRAM_O = s_ff.sram;
    assign FLASH_O = s_ff.flash;
    assign ISP_MODE_O = s_ff.isp;

    // Checks
    a_bad_key_halt: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (s_ff.st == S_CHK) && (s_ff.prm[fsc_pkg::PRM_GUARD1] != fsc_pkg::GUARD1_VALUE)
        |=> HALT_O)
        else $error("bad first key did not halt");
    a_undef_halt: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        call_go && user_go && (ACC_I != fsc_pkg::FN_BOOT) && !fn_known(ACC_I)
        |=> HALT_O && (s_ff.st == S_HALT))
        else $error("undefined function did not halt");
    a_refuse_clr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        ACC_CLR_O |-> SRAM_O.req && SRAM_O.we && (SRAM_O.wdata == fsc_pkg::RC_PROT))
        else $error("refusal did not store protection code");
    a_busy_block: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (s_ff.st == S_PRM) |-> !CALL_READY_O && !call_go)
        else $error("call accepted while busy");
    a_rom_vis: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        FLASH_O.start |-> ROM_ACTIVE_O)
        else $error("flash started outside supervisory rom");
    a_no_aux: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        FLASH_O.start && (s_ff.func == fsc_pkg::FN_ERASE_ALL) |->
        (FLASH_O.tgt != fsc_pkg::TGT_USER))
        else $error("full erase aimed at wrong target");
    a_prot_pass: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        $rose(s_ff.phase) |-> (FLASH_O.tgt == fsc_pkg::TGT_PROT) &&
        (FLASH_O.op == fsc_pkg::FOP_ERASE) && $past(s_ff.step) == 2'h2)
        else $error("protection pass began wrongly");
    a_trap_entry: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        call_go && user_go && fn_known(ACC_I) |=> (s_ff.st == S_PRM) &&
        (SRAM_O.addr == fsc_pkg::PRM_BASE) ##1 ROM_ACTIVE_O)
        else $error("trap did not enter the rom");
    a_isp_entry: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        $rose(ISP_MODE_O) |-> $past(s_ff.dp2) && !$past(s_ff.dm2))
        else $error("programming mode entered without pin pattern");
    c_refused: cover property (@(posedge CLK_I) disable iff (!RST_N_I) ACC_CLR_O);
    c_erase_all: cover property (@(posedge CLK_I) disable iff (!RST_N_I) $rose(s_ff.phase));
    c_halted: cover property (@(posedge CLK_I) disable iff (!RST_N_I) $rose(HALT_O));
    c_isp: cover property (@(posedge CLK_I) disable iff (!RST_N_I) $rose(ISP_MODE_O));
endmodule : fsc_unit
`default_nettype wire

/* tb/fsc_far.sv */
// Far-side model: parameter SRAM, flash engine and protection lookup
`default_nettype none
module fsc_far (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Parameter SRAM side
    input wire fsc_pkg::fsc_sram_s sram_i,
    output logic ack_o,
    output logic [7:0] rdata_o,
    // Flash engine side
    input wire fsc_pkg::fsc_flash_s flash_i,
    input wire logic err_i,
    input wire logic [1:0] lvl_i,
    input wire logic [3:0] lat_i,
    output logic done_o,
    output logic err_o,
    output logic [7:0] fdata_o,
    output logic [1:0] prot_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:7];  // Slots F8h..FFh in order
    logic [7:0] log_q [0:31];  // Started ops as op, target, block
    int n_ops;
    int fcnt;
    int scnt;
    // Level of whichever block is shown
    assign prot_o = lvl_i;
    // SRAM answers wait lat_i cycles, flash answers one more; released data is inverted, not held
    always @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        done_o <= 1'b0;
        err_o <= 1'b0;
        rdata_o <= ~rdata_o;
        fdata_o <= ~fdata_o;
        scnt <= sram_i.req ? scnt + 1 : 0;
        if (!rst_n_i)
        begin
            n_ops <= 0;
            fcnt <= 0;
            rdata_o <= 8'h00;
            fdata_o <= 8'h00;
        end
        else
        begin
            // One byte per acknowledge
            if (sram_i.req && !ack_o && scnt >= 32'(lat_i))
            begin
                ack_o <= 1'b1;
                scnt <= 0;
                rdata_o <= mem[sram_i.addr[2:0]];
                if (sram_i.we)
                    mem[sram_i.addr[2:0]] <= sram_i.wdata;
            end
            if (flash_i.start)
            begin
                log_q[n_ops[4:0]] <= {flash_i.op, flash_i.tgt, flash_i.blk[2:0]};
                n_ops <= n_ops + 1;
                fcnt <= 32'(lat_i) + 1;
            end
            else if (fcnt == 1)
            begin
                done_o <= 1'b1;
                err_o <= err_i;
                fdata_o <= {5'h18, flash_i.op};
            end
            if (!flash_i.start && fcnt > 0)
                fcnt <= fcnt - 1;
        end
    end
endmodule : fsc_far
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the supervisory call unit
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NM = 2;  // Macros, kept small
    localparam int NP = 2;  // Protection blocks
    // Driven inputs; stack pointer wraps when the key is formed
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic call_v = 1'b0;
    logic tq_v = 1'b0;
    logic err = 1'b0;
    logic dp = 1'b0;
    logic dm = 1'b1;
    logic [7:0] opc = 8'h00;
    logic [7:0] acc = 8'h00;
    logic [7:0] sp = 8'hFE;  // Caller keeps its stack room clear
    logic [1:0] lvl = 2'h0;
    logic [3:0] lat = 4'h0;
    // Observed outputs
    logic ready, clr, halt, rom, isp, ack, done, ferr;
    logic [7:0] rdata, fdata;
    logic [1:0] prot;
    fsc_pkg::fsc_sram_s sram;
    fsc_pkg::fsc_flash_s flash;
    int fails = 0;
    int n_tests = 0;
    int clr_n, rom_n, n0;
    // Function, level, expected result slot, clear pulses
    localparam logic [7:0] ROWS [0:11][0:3] = '{
        '{8'h01, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h01, 8'h01, 8'h01},
        '{8'h01, 8'h02, 8'h00, 8'h00}, '{8'h02, 8'h00, 8'h00, 8'h00},
        '{8'h02, 8'h02, 8'h00, 8'h00}, '{8'h02, 8'h03, 8'h01, 8'h01},
        '{8'h03, 8'h00, 8'h00, 8'h00}, '{8'h03, 8'h03, 8'h01, 8'h01},
        '{8'h06, 8'h00, 8'hC5, 8'h00}, '{8'h07, 8'h00, 8'hC6, 8'h00},
        '{8'h05, 8'h00, 8'h00, 8'h00}, '{8'h00, 8'h00, 8'h02, 8'h00}};
    always #4 clk = ~clk;
    fsc_unit #(.N_MACRO(NM), .N_PROT(NP)) fsc_unit_inst (.CLK_I(clk), .RST_N_I(rst_n),
        .CALL_VALID_I(call_v), .OPCODE_I(opc), .ACC_I(acc), .SP_I(sp), .CALL_READY_O(ready),
        .ACC_CLR_O(clr), .HALT_O(halt), .ROM_ACTIVE_O(rom), .SRAM_O(sram), .SRAM_ACK_I(ack),
        .SRAM_RDATA_I(rdata), .FLASH_O(flash), .FLASH_DONE_I(done), .FLASH_ERR_I(ferr),
        .FLASH_DATA_I(fdata), .PROT_LEVEL_I(prot), .USB_DP_I(dp), .USB_DM_I(dm),
        .TQ_VALID_I(tq_v), .TQ_FUNC_I(acc), .ISP_MODE_O(isp));
    fsc_far fsc_far_inst (.clk_i(clk), .rst_n_i(rst_n), .sram_i(sram), .ack_o(ack),
        .rdata_o(rdata), .flash_i(flash), .err_i(err), .lvl_i(lvl), .lat_i(lat),
        .done_o(done), .err_o(ferr), .fdata_o(fdata), .prot_o(prot));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    // Expected full-erase step k: op, target, block
    function automatic logic [7:0] ea(input int k);
        int j;
        j = (k < 3 * NM) ? k % 3 : (k - 3 * NM) % 2;
        return {(j == 1) ? 3'h4 : 3'h3, (k < 3 * NM) ? 2'h1 : 2'h2,
                3'((k < 3 * NM) ? k / 3 : (k - 3 * NM) / 2)};
    endfunction : ea
    // Reset for 16 cycles, then the unit boots alone and writes nothing
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        fsc_far_inst.mem[0] = 8'h77;
        rst_n <= 1'b1;
        for (int i = 0; i < 100 && ready !== 1'b1; i++)
            @(negedge clk);
        chk({7'h00, ready}, 8'h01, "idle");
        chk(fsc_far_inst.log_q[0] >> 5, 8'h00, "boot op");
        chk(fsc_far_inst.mem[0], 8'h77, "boot slot");
    endtask : do_reset
    // Call held over two edges; the second edge must be ignored
    task automatic call(input logic [7:0] fn, input logic [7:0] k1, input logic [7:0] k2,
                        input logic [1:0] lv, input logic by_tq);
        fsc_far_inst.mem[0] = k1;
        fsc_far_inst.mem[1] = k2;
        fsc_far_inst.mem[2] = 8'h05;
        clr_n = 0;
        rom_n = 0;
        n0 = fsc_far_inst.n_ops;
        @(posedge clk);
        acc <= fn;
        lvl <= lv;
        call_v <= !by_tq;
        tq_v <= by_tq;
        repeat (2) @(posedge clk);
        call_v <= 1'b0;
        tq_v <= 1'b0;
        for (int i = 0; i < 600 && ready !== 1'b1 && halt !== 1'b1; i++)
        begin
            @(negedge clk);
            clr_n += clr;
            rom_n += rom;
        end
    endtask : call
    initial
    begin
        #400000;
        fails++;
        test_done();
    end
    initial
    begin
        do_reset();
        // Ordinary functions, prompt and slow far side in turn
        for (int i = 0; i < 12; i++)
        begin
            lat <= i[0] ? 4'h5 : 4'h0;
            call(ROWS[i][0], (ROWS[i][0] == 8'h00) ? 8'h11 : 8'h3A, sp + 8'h03,
                 ROWS[i][1][1:0], 1'b0);
            chk(fsc_far_inst.mem[0], ROWS[i][2], "result");
            chk(8'(clr_n), ROWS[i][3], "acc clear");
            chk({7'h00, halt}, 8'h00, "halt");
            chk(8'(rom_n != 0), 8'h01, "rom");
            if (ROWS[i][3] == 8'h01)
                chk(fsc_far_inst.mem[1], 8'h00, "second_guard_key");
            if (ROWS[i][0] == 8'h05)
                chk(8'(fsc_far_inst.n_ops - n0), 8'(3 * NM + 2 * NP), "ops");
            for (int k = 0; ROWS[i][0] == 8'h05 && k < 3 * NM + 2 * NP; k++)
                chk(fsc_far_inst.log_q[n0 + k], ea(k), "erase");
        end
        // Undefined code, bad first key, bad second key
        for (int i = 0; i < 3; i++)
        begin
            call((i == 0) ? 8'h04 : 8'h01, (i == 1) ? 8'h3B : 8'h3A,
                 sp + ((i == 2) ? 8'h02 : 8'h03), 2'h0, 1'b0);
            chk({7'h00, halt}, 8'h01, "halt");
            do_reset();
        end
        // Other opcode is no call
        @(posedge clk);
        opc <= 8'h40;
        call_v <= 1'b1;
        repeat (3) @(posedge clk);
        call_v <= 1'b0;
        opc <= 8'h00;
        @(negedge clk);
        chk({6'h00, sram.req, ready}, 8'h01, "opcode");
        // Flash failure gives the fatal code then halts
        err <= 1'b1;
        call(8'h03, 8'h3A, sp + 8'h03, 2'h0, 1'b0);
        chk(fsc_far_inst.mem[0], 8'h03, "fatal");
        chk({7'h00, halt}, 8'h01, "fatal halt");
        err <= 1'b0;
        do_reset();
        // Pin pattern, then test-queue calls
        @(posedge clk);
        dp <= 1'b1;
        dm <= 1'b0;
        repeat (100) @(negedge clk);
        chk({7'h00, isp}, 8'h00, "isp early");
        repeat (40) @(negedge clk);
        chk({7'h00, isp}, 8'h01, "isp");
        call(8'h02, 8'h3A, sp + 8'h03, 2'h2, 1'b1);
        chk(fsc_far_inst.mem[0], 8'h01, "tq write");
        call(8'h04, 8'h3A, sp + 8'h03, 2'h0, 1'b1);
        chk({7'h00, halt}, 8'h00, "tq undefined");
        test_done();
    end
endmodule : tb
`default_nettype wire
